// File: rtl/sfsr_top.v
// Status register bank of a serial flash: serial command front end, the
// status byte, protection checks and the handshake to the array engine.
// Assumes SPI mode 0 on the pins, sampled by clk_i well above the link rate,
// and an external array engine that runs program and erase operations.
`include "sfsr_map.vh"

module sfsr_top (
  input  wire        clk_i,           // System clock, 100 MHz
  input  wire        srst_i,          // Synchronous reset (power-up/hardware)
  input  wire        sck_i,           // Serial clock pin
  input  wire        cs_n_i,          // Chip select pin, active low
  input  wire        mosi_i,          // Serial data in pin
  input  wire        wp_n_i,          // Write-protect pin, active low
  input  wire        op_done_i,       // Engine: operation finished pulse
  input  wire        op_fail_i,       // Engine: failure qualifier with done
  input  wire        addr_protected_i,// Engine: op_addr_o lies in locked area
  output reg         miso_o,          // Serial data out
  output reg         miso_oe_n_o,     // Data out enable, low while driving
  output reg         op_start_o,      // Start pulse to array engine
  output reg  [1:0]  op_kind_o,       // Kind of started operation
  output reg  [23:0] op_addr_o,       // Target address of operation
  output reg         op_suspend_o,    // Suspend pulse to array engine
  output reg         op_abort_o,      // Abort pulse on software reset while an operation is outstanding
  output reg  [7:0]  status_o,        // Copy of the status byte
  output reg  [1:0]  config_o         // Volatility select, freeze
);

  // ----------------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------------
  wire sck_s;
  wire cs_n_s;
  wire mosi_s;
  wire wp_n_s;

  sfsr_sync u_sync_sck (
    .clk_i     (clk_i),
    .srst_i    (srst_i),
    .rst_val_i (1'b0),
    .pin_i     (sck_i),
    .level_o   (sck_s)
  );
  sfsr_sync u_sync_cs (
    .clk_i     (clk_i),
    .srst_i    (srst_i),
    .rst_val_i (1'b1),
    .pin_i     (cs_n_i),
    .level_o   (cs_n_s)
  );
  sfsr_sync u_sync_mosi (
    .clk_i     (clk_i),
    .srst_i    (srst_i),
    .rst_val_i (1'b0),
    .pin_i     (mosi_i),
    .level_o   (mosi_s)
  );
  sfsr_sync u_sync_wp (
    .clk_i     (clk_i),
    .srst_i    (srst_i),
    .rst_val_i (1'b1),
    .pin_i     (wp_n_i),
    .level_o   (wp_n_s)
  );

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  reg        sck_d;          // Previous filtered clock level
  reg        cs_n_d;         // Previous filtered select level
  reg [5:0]  bit_cnt;        // Bits in this frame, saturating
  reg [2:0]  out_pos;        // Bit position of the read-out byte
  reg [7:0]  shift_in;       // Incoming bits
  reg [7:0]  opcode;         // Latched command
  reg [23:0] addr_sh;        // Address collector
  reg [15:0] wdata;          // Register-write data collector
  reg [7:0]  out_sh;         // Read-out shifter
  reg        lock_bit;       // Status write lock
  reg        prog_err;       // Program error flag
  reg        erase_err;      // Erase error flag
  reg [2:0]  range_bits;     // Protection range
  reg        write_enable_latch;            // Write enable latch
  reg        busy;           // Busy flag
  reg        vol_sel;        // Protection volatility select
  reg        freeze;         // Range freeze
  reg        op_run;         // Engine operation outstanding
  reg [1:0]  run_kind;       // Kind of outstanding operation
  reg        susp_pend;      // Suspend issued, waiting for engine

  wire       sck_rise = sck_s & ~sck_d;
  wire       sck_fall = ~sck_s & sck_d;
  wire       cs_rise  = cs_n_s & ~cs_n_d;
  wire       cs_act   = ~cs_n_s;
  wire [7:0] opc_now  = {shift_in[6:0], mosi_s};
  wire [7:0] stat_now = {lock_bit, prog_err, erase_err, range_bits, write_enable_latch, busy};
  wire [7:0] stat2_now = `SFSR_STAT2_VALUE; // Second status byte, fixed value
  wire       any_err  = prog_err | erase_err;

  // Commands that may pass while busy
  wire busy_ok = (opcode == `SFSR_OP_READ_STAT) || (opcode == `SFSR_OP_READ_STAT2) ||
                 (opcode == `SFSR_OP_ERASE_SUSP) || (opcode == `SFSR_OP_PROG_SUSP) ||
                 (opcode == `SFSR_OP_CLEAR_STAT) || (opcode == `SFSR_OP_SOFT_RESET);
  // Command is executed at select release with at least an opcode
  wire exec     = cs_rise && (bit_cnt >= `SFSR_BITS_OPCODE) && (!busy || busy_ok);
  wire exec_one = exec && (bit_cnt == `SFSR_BITS_OPCODE);
  wire sw_reset = exec_one && (opcode == `SFSR_OP_SOFT_RESET);
  wire is_read  = (opcode == `SFSR_OP_READ_STAT) || (opcode == `SFSR_OP_READ_STAT2);
  wire hw_lock  = lock_bit & ~wp_n_s;

  // ----------------------------------------------------------------------------
  // Serial front end
  // ----------------------------------------------------------------------------
  // Edges are found on filtered levels so one-cycle glitches on the pins never count
  always @(posedge clk_i) begin
    if (srst_i) begin
      sck_d       <= 1'b0;
      cs_n_d      <= 1'b1;
      bit_cnt     <= 6'h00;
      out_pos     <= 3'h0;
      shift_in    <= 8'h00;
      opcode      <= 8'h00;
      addr_sh     <= 24'h000000;
      wdata       <= 16'h0000;
      out_sh      <= 8'h00;
      miso_o      <= 1'b0;
      miso_oe_n_o <= 1'b1;
    end else begin
      sck_d  <= sck_s;
      cs_n_d <= cs_n_s;
      if (!cs_act) begin
        bit_cnt     <= 6'h00;
        out_pos     <= 3'h0;
        miso_oe_n_o <= 1'b1;
      end else if (sck_rise) begin
        shift_in <= opc_now;
        if (bit_cnt != `SFSR_BITS_SAT) begin
          bit_cnt <= bit_cnt + 6'h01;
        end
        if (bit_cnt == 6'h07) begin
          opcode <= opc_now;
        end
        if ((bit_cnt >= `SFSR_BITS_OPCODE) && (bit_cnt < `SFSR_BITS_ADDR)) begin
          addr_sh <= {addr_sh[22:0], mosi_s};
        end
        if ((bit_cnt >= `SFSR_BITS_OPCODE) && (bit_cnt < `SFSR_BITS_WR2)) begin
          wdata <= {wdata[14:0], mosi_s};
        end
      end else if (sck_fall && (bit_cnt >= `SFSR_BITS_OPCODE) && is_read) begin
        // Each byte reloads the live status, so polling sees busy drop
        out_pos     <= out_pos + 3'h1;
        miso_oe_n_o <= 1'b0;
        if (out_pos == 3'h0) begin
          if (opcode == `SFSR_OP_READ_STAT) begin
            out_sh <= {stat_now[6:0], 1'b0};
            miso_o <= stat_now[7];
          end else begin
            out_sh <= {stat2_now[6:0], 1'b0};
            miso_o <= stat2_now[7];
          end
        end else begin
          out_sh <= {out_sh[6:0], 1'b0};
          miso_o <= out_sh[7];
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Status and configuration bits, engine handshake
  // ----------------------------------------------------------------------------
  // Command effects come first; engine results follow so a flag that the
  // engine sets in the same cycle as a clear-status still survives
  always @(posedge clk_i) begin
    if (srst_i) begin
      lock_bit     <= 1'b0;
      prog_err     <= 1'b0;
      erase_err    <= 1'b0;
      range_bits   <= `SFSR_RANGE_SHIP;
      write_enable_latch          <= 1'b0;
      busy         <= 1'b0;
      vol_sel      <= 1'b0;
      freeze       <= 1'b0;
      op_run       <= 1'b0;
      run_kind     <= `SFSR_KIND_NONE;
      susp_pend    <= 1'b0;
      op_start_o   <= 1'b0;
      op_kind_o    <= `SFSR_KIND_NONE;
      op_addr_o    <= 24'h000000;
      op_suspend_o <= 1'b0;
      op_abort_o   <= 1'b0;
    end else begin
      op_start_o   <= 1'b0;
      op_suspend_o <= 1'b0;
      op_abort_o   <= 1'b0;
      if (exec) begin
        case (opcode)
          `SFSR_OP_WRITE_EN: begin
            if (bit_cnt == `SFSR_BITS_OPCODE) begin
              write_enable_latch <= 1'b1;
            end
          end
          `SFSR_OP_WRITE_DIS: begin
            if (bit_cnt == `SFSR_BITS_OPCODE) begin
              write_enable_latch <= 1'b0;
            end
          end
          `SFSR_OP_CLEAR_STAT: begin
            prog_err  <= 1'b0;
            erase_err <= 1'b0;
            if (any_err) begin
              busy <= 1'b0;
            end
          end
          `SFSR_OP_REG_WRITE: begin
            // Rejected without a latch or under pin lock; flags are untouched
            if (write_enable_latch && !hw_lock && ((bit_cnt == `SFSR_BITS_WR1) ||
                                    (bit_cnt == `SFSR_BITS_WR2))) begin
              if (bit_cnt == `SFSR_BITS_WR1) begin
                lock_bit <= wdata[`SFSR_ST_LOCK];
                if (!freeze) begin
                  range_bits <= wdata[`SFSR_ST_RANGE_HI:`SFSR_ST_RANGE_LO];
                end
              end else begin
                lock_bit <= wdata[8 + `SFSR_ST_LOCK];
                if (!freeze) begin
                  range_bits <= wdata[8 + `SFSR_ST_RANGE_HI:8 + `SFSR_ST_RANGE_LO];
                end
                // Volatility is one-time: it may only go from 0 to 1
                vol_sel <= vol_sel | wdata[`SFSR_CF_VOLATILITY];
                freeze  <= freeze | wdata[`SFSR_CF_FREEZE];
              end
              write_enable_latch <= 1'b0;
            end
          end
          `SFSR_OP_PAGE_PROG, `SFSR_OP_SECT_ERASE, `SFSR_OP_SECT_ERASE4K: begin
            if (write_enable_latch && (bit_cnt >= `SFSR_BITS_ADDR)) begin
              busy      <= 1'b1;
              op_addr_o <= addr_sh;
              if (addr_protected_i) begin
                // Refused; the error keeps busy high until clear-status or software reset
                if (opcode == `SFSR_OP_PAGE_PROG) begin
                  prog_err <= 1'b1;
                end else begin
                  erase_err <= 1'b1;
                end
              end else begin
                op_start_o <= 1'b1;
                op_run     <= 1'b1;
                if (opcode == `SFSR_OP_PAGE_PROG) begin
                  op_kind_o <= `SFSR_KIND_PROG;
                  run_kind  <= `SFSR_KIND_PROG;
                end else begin
                  op_kind_o <= `SFSR_KIND_ERASE;
                  run_kind  <= `SFSR_KIND_ERASE;
                end
              end
            end
          end
          `SFSR_OP_ARRAY_ERASE_A, `SFSR_OP_ARRAY_ERASE_B: begin
            // Any protection makes the whole-array erase a silent no-op
            if (write_enable_latch && (bit_cnt == `SFSR_BITS_OPCODE) && (range_bits == 3'h0)) begin
              busy       <= 1'b1;
              op_start_o <= 1'b1;
              op_run     <= 1'b1;
              op_kind_o  <= `SFSR_KIND_WHOLE;
              run_kind   <= `SFSR_KIND_WHOLE;
              op_addr_o  <= 24'h000000;
            end
          end
          `SFSR_OP_ERASE_SUSP: begin
            if (op_run && !any_err && !susp_pend && (run_kind != `SFSR_KIND_PROG)) begin
              op_suspend_o <= 1'b1;
              susp_pend    <= 1'b1;
            end
          end
          `SFSR_OP_PROG_SUSP: begin
            if (op_run && !any_err && !susp_pend && (run_kind == `SFSR_KIND_PROG)) begin
              op_suspend_o <= 1'b1;
              susp_pend    <= 1'b1;
            end
          end
          `SFSR_OP_SOFT_RESET: begin
            if (sw_reset) begin
              write_enable_latch        <= 1'b0;
              prog_err   <= 1'b0;
              erase_err  <= 1'b0;
              busy       <= 1'b0;
              freeze     <= 1'b0;
              op_run     <= 1'b0;
              susp_pend  <= 1'b0;
              op_abort_o <= op_run;
              if (vol_sel) begin
                range_bits <= `SFSR_RANGE_VOL_RST;
              end
            end
          end
          default: begin
          end
        endcase
      end
      // Engine result; a software reset in the same cycle discards it
      if (op_run && op_done_i && !sw_reset) begin
        op_run    <= 1'b0;
        susp_pend <= 1'b0;
        if (op_fail_i) begin
          // Flag rises while busy is still high and busy then holds
          if (run_kind == `SFSR_KIND_PROG) begin
            prog_err <= 1'b1;
          end else begin
            erase_err <= 1'b1;
          end
        end else begin
          busy <= 1'b0;
          if (!susp_pend) begin
            write_enable_latch <= 1'b0;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Registered copies for the outputs
  // ----------------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (srst_i) begin
      status_o <= 8'h00;
      config_o <= 2'h0;
    end else begin
      status_o <= stat_now;
      config_o <= {vol_sel, freeze};
    end
  end
endmodule // sfsr_top

// File: rtl/sfsr_map.vh
// Constants for the serial flash status register block: opcodes, bit fields,
// operation kinds and reset values.
// Assumes inclusion by bare name from rtl/ files; definitions only.
`ifndef SFSR_MAP_VH
`define SFSR_MAP_VH

// ----------------------------------------------------------------------------
// Command opcodes
// ----------------------------------------------------------------------------
`define SFSR_OP_REG_WRITE     8'h01
`define SFSR_OP_PAGE_PROG     8'h02
`define SFSR_OP_WRITE_DIS     8'h04
`define SFSR_OP_READ_STAT     8'h05
`define SFSR_OP_WRITE_EN      8'h06
`define SFSR_OP_READ_STAT2    8'h07
`define SFSR_OP_SECT_ERASE4K  8'h20
`define SFSR_OP_CLEAR_STAT    8'h30
`define SFSR_OP_ARRAY_ERASE_A 8'h60
`define SFSR_OP_ERASE_SUSP    8'h75
`define SFSR_OP_PROG_SUSP     8'h85
`define SFSR_OP_ARRAY_ERASE_B 8'hC7
`define SFSR_OP_SECT_ERASE    8'hD8
`define SFSR_OP_SOFT_RESET    8'hF0

// ----------------------------------------------------------------------------
// Status and configuration bit positions
// ----------------------------------------------------------------------------
`define SFSR_ST_LOCK          7
`define SFSR_ST_PROG_ERR      6
`define SFSR_ST_ERASE_ERR     5
`define SFSR_ST_RANGE_HI      4
`define SFSR_ST_RANGE_LO      2
`define SFSR_ST_WEL           1
`define SFSR_ST_BUSY          0
`define SFSR_CF_VOLATILITY    3
`define SFSR_CF_FREEZE        0

// ----------------------------------------------------------------------------
// Bit counts of command frames
// ----------------------------------------------------------------------------
`define SFSR_BITS_OPCODE      6'h08
`define SFSR_BITS_WR1         6'h10
`define SFSR_BITS_WR2         6'h18
`define SFSR_BITS_ADDR        6'h20
`define SFSR_BITS_SAT         6'h3F

// ----------------------------------------------------------------------------
// Operation kinds and reset values
// ----------------------------------------------------------------------------
`define SFSR_KIND_NONE        2'h0
`define SFSR_KIND_PROG        2'h1
`define SFSR_KIND_ERASE       2'h2
`define SFSR_KIND_WHOLE       2'h3
`define SFSR_RANGE_VOL_RST    3'h7
`define SFSR_RANGE_SHIP       3'h0
`define SFSR_STAT2_VALUE      8'h00

`endif

// File: rtl/sfsr_sync.v
// Three-stage synchroniser with agreement filter for one pin input.
// Assumes the pin is asynchronous to clk_i; output moves only when the
// second and third stages agree.
module sfsr_sync (
  input  wire clk_i,   // System clock
  input  wire srst_i,  // Synchronous reset, active high
  input  wire rst_val_i, // Level shown during reset (tie to a constant)
  input  wire pin_i,   // Asynchronous pin level
  output reg  level_o  // Filtered level
);
  reg s1;
  reg s2;
  reg s3;

  // ----------------------------------------------------------------------------
  // Stages and filter
  // ----------------------------------------------------------------------------
  // First stage feeds only the second, keeping metastability out of logic
  always @(posedge clk_i) begin
    if (srst_i) begin
      s1      <= rst_val_i;
      s2      <= rst_val_i;
      s3      <= rst_val_i;
      level_o <= rst_val_i;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level_o <= s3;
      end
    end
  end
endmodule // sfsr_sync

// File: verif/sfsr_top_assertions.sv
// Port-level checker for the status register block.
// Assumes binding to sfsr_top; one clock domain, clk_i with srst_i.
module sfsr_top_checker (
  input logic       clk_i,        // System clock
  input logic       srst_i,       // Synchronous reset
  input logic       cs_n_i,       // Chip select pin
  input logic       miso_oe_n_o,  // Data out enable, low active
  input logic       op_start_o,   // Operation start pulse
  input logic [1:0] op_kind_o,    // Kind of operation
  input logic       op_suspend_o, // Suspend pulse
  input logic [7:0] status_o      // Status byte copy
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // ---------------------------------------------------------------
  // Sequences
  // ---------------------------------------------------------------
  // Busy shows shortly after a start; status_o lags one cycle
  sequence s_busy_soon;
    ##[1:3] status_o[0];
  endsequence
  // Deselected long enough for the synchronisers to settle
  sequence s_cs_idle;
    cs_n_i [*8];
  endsequence
  a_start_needs_latch: assert property (op_start_o |-> ##2 status_o[1])
    else $error("start with write enable clear");
  a_start_sets_busy: assert property (op_start_o |-> s_busy_soon)
    else $error("busy not raised after start");
  a_start_when_idle: assert property (op_start_o |-> !$past(status_o[0]))
    else $error("start taken while busy");
  a_whole_needs_open: assert property (
    op_start_o && op_kind_o == 2'h3 |-> status_o[4:2] == 3'h0)
    else $error("whole erase with range bits set");
  a_error_keeps_busy: assert property ((status_o[6] || status_o[5]) |-> status_o[0])
    else $error("error flag without busy");
  a_latch_rise_idle: assert property ($rose(status_o[1]) |-> !$past(status_o[0]))
    else $error("latch set while busy");
  a_idle_bus_released: assert property (s_cs_idle |-> miso_oe_n_o)
    else $error("data out driven while deselected");
  a_suspend_when_busy: assert property (op_suspend_o |-> status_o[0])
    else $error("suspend while idle");
endmodule // sfsr_top_checker

bind sfsr_top sfsr_top_checker u_chk (
  .clk_i(clk_i), .srst_i(srst_i), .cs_n_i(cs_n_i), .miso_oe_n_o(miso_oe_n_o),
  .op_start_o(op_start_o), .op_kind_o(op_kind_o), .op_suspend_o(op_suspend_o),
  .status_o(status_o));

// File: verif/sfsr_host_model.sv
// Host serial controller model: mode 0 frames, MSB first.
// Assumes clk_i paces the link; half an sck period is four clk cycles.
module sfsr_host_model (
  input  wire logic clk_i,  // System clock
  input  wire logic miso_i, // Serial data from the device
  output logic      sck_o,  // Serial clock, still outside frames
  output logic      cs_n_o, // Chip select, active low
  output logic      mosi_o  // Serial data to the device
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // One frame of n bits from the top of d; reply bits after the opcode
  task automatic frame(input logic [31:0] d, input int n, output logic [7:0] rd);
    rd = 8'h00;
    @(negedge clk_i);
    cs_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      sck_o = 1'b0;
      mosi_o = d[31 - i];
      repeat (4) @(negedge clk_i);
      sck_o = 1'b1;
      repeat (4) @(negedge clk_i);
      // Sampled late in the high phase: the reply stands until the fall
      if (i >= 8) rd = {rd[6:0], miso_i};
    end
    sck_o = 1'b0;
    mosi_o = ~mosi_o; // Released line must not keep its last value
    repeat (4) @(negedge clk_i);
    cs_n_o = 1'b1;
    repeat (8) @(negedge clk_i);
  endtask
endmodule // sfsr_host_model

// File: verif/test_serial_flash_status_register.sv
// Testbench for the status register block: command frames from the host
// model, a hand-driven array engine, status checked on status_o and by reads.
module test_serial_flash_status_register;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
    $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
  logic        clk_i = 1'b0, srst_i = 1'b1, wp_n_i = 1'b1;
  logic        op_done_i = 1'b0, op_fail_i = 1'b0, prot_i = 1'b0;
  wire         sck, cs_n, mosi, miso, oe_n, start, susp, abort;
  wire  [1:0]  kind, cfg;
  wire  [23:0] addr;
  wire  [7:0]  status;
  logic [7:0]  rd;
  int          miscompares = 0, comparisons = 0, starts = 0, susps = 0, aborts = 0;
  initial forever #5 clk_i = ~clk_i;
  sfsr_top dut (.clk_i(clk_i), .srst_i(srst_i), .sck_i(sck), .cs_n_i(cs_n),
    .mosi_i(mosi), .wp_n_i(wp_n_i), .op_done_i(op_done_i), .op_fail_i(op_fail_i),
    .addr_protected_i(prot_i), .miso_o(miso), .miso_oe_n_o(oe_n), .op_start_o(start),
    .op_kind_o(kind), .op_addr_o(addr), .op_suspend_o(susp), .op_abort_o(abort),
    .status_o(status), .config_o(cfg));
  sfsr_host_model host (.clk_i(clk_i), .miso_i(miso), .sck_o(sck), .cs_n_o(cs_n),
    .mosi_o(mosi));
  // Engine pulses counted as they happen
  always @(posedge clk_i) begin
    if (start === 1'b1) starts++;
    if (susp === 1'b1) susps++;
    if (abort === 1'b1) aborts++;
  end
  task cmd(input logic [31:0] d, input int n);
    host.frame(d, n, rd);
  endtask
  // Status compared on the port copy and through a read-status frame
  task chk(input logic [7:0] e, input logic [7:0] m);
    repeat (4) @(negedge clk_i);
    `CHK(status & m, e)
    host.frame(32'h0500_0000, 16, rd);
    `CHK(rd & m, e)
  endtask
  task done(input logic f);
    @(negedge clk_i);
    op_fail_i = f;
    op_done_i = 1'b1;
    @(negedge clk_i);
    op_done_i = 1'b0;
    op_fail_i = 1'b0;
  endtask
  task summarize;
    if (miscompares == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Whole run is near 7k cycles; the limit leaves ample margin
  initial begin
    #600us;
    miscompares++;
    summarize;
  end
  // ---------------------------------------------------------------
  // Command sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(negedge clk_i);
    srst_i = 1'b0;
    repeat (10) @(negedge clk_i);
    chk(8'h00, 8'hFF);
    cmd(32'h0600_0000, 8);
    chk(8'h02, 8'hFF);
    cmd(32'h01FC_0000, 16);
    chk(8'h9C, 8'hFD);
    wp_n_i = 1'b0;
    cmd(32'h0600_0000, 8);
    cmd(32'h0100_0000, 16);
    chk(8'h9C, 8'hFD);
    wp_n_i = 1'b1;
    cmd(32'h0600_0000, 8);
    cmd(32'h010C_0000, 16);
    chk(8'h0C, 8'hFD);
    cmd(32'h0600_0000, 8);
    cmd(32'h6000_0000, 8);
    chk(8'h0E, 8'hFF);
    `CHK(starts, 0)
    cmd(32'h0400_0000, 8);
    chk(8'h0C, 8'hFF);
    cmd(32'h0100_0000, 16);
    chk(8'h0C, 8'hFF);
    cmd(32'h0600_0000, 8);
    cmd(32'h0100_0000, 16);
    cmd(32'h0400_0000, 8);
    cmd(32'h0600_0000, 8);
    cmd(32'h0212_3456, 32);
    chk(8'h03, 8'hFF);
    `CHK(starts, 1)
    `CHK({kind, addr}, {2'h1, 24'h12_3456})
    cmd(32'h7500_0000, 8);
    cmd(32'h0400_0000, 8);
    chk(8'h03, 8'hFF);
    `CHK(susps, 0)
    done(1'b0);
    chk(8'h00, 8'hFF);
    cmd(32'h0600_0000, 8);
    cmd(32'hD801_0000, 32);
    done(1'b1);
    chk(8'h23, 8'hFF);
    cmd(32'h3000_0000, 8);
    chk(8'h02, 8'hFF);
    cmd(32'h0400_0000, 8);
    chk(8'h00, 8'hFF);
    prot_i = 1'b1;
    cmd(32'h0600_0000, 8);
    cmd(32'h0200_0100, 32);
    chk(8'h43, 8'hFF);
    `CHK(starts, 2)
    cmd(32'h3000_0000, 8);
    cmd(32'h0400_0000, 8);
    prot_i = 1'b0;
    chk(8'h00, 8'hFF);
    cmd(32'h0600_0000, 8);
    cmd(32'hC700_0000, 8);
    `CHK(kind, 2'h3)
    cmd(32'h8500_0000, 8);
    `CHK(susps, 0)
    cmd(32'h7500_0000, 8);
    `CHK(susps, 1)
    done(1'b0);
    chk(8'h02, 8'hFF);
    // Two-byte register write: volatile range bits, then freeze them
    cmd(32'h0100_0900, 24);
    `CHK(cfg, 2'h3)
    cmd(32'h0600_0000, 8);
    cmd(32'h011C_0000, 16);
    chk(8'h00, 8'hFF);
    // Software reset mid-program: abort, latch cleared, range bits to ones
    cmd(32'h0600_0000, 8);
    cmd(32'h0234_5600, 32);
    cmd(32'h0700_0000, 16);
    `CHK(rd, 8'h00)
    cmd(32'hF000_0000, 8);
    chk(8'h1C, 8'hFF);
    `CHK(aborts, 1)
    `CHK(cfg, 2'h2)
    srst_i = 1'b1;
    repeat (16) @(negedge clk_i);
    srst_i = 1'b0;
    repeat (10) @(negedge clk_i);
    chk(8'h00, 8'hFF);
    `CHK(cfg, 2'h0)
    summarize;
  end
endmodule // test_serial_flash_status_register
